// ==== hw/adc_readout_defs.svh ====
`ifndef ADC_READOUT_DEFS_SVH
`define ADC_READOUT_DEFS_SVH

// ----------------------------------------
// Clock and conversion timing
// ----------------------------------------
`define MCLK_HZ 100000000
`define MCLK_PERIOD_NS 10
`define DATA_RATE_SPS 15
`define CONV_CYCLES_DEF (`MCLK_HZ / `DATA_RATE_SPS)
`define UPDATE_NS 50000
`define UPDATE_CYCLES_DEF ((`UPDATE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define SLEEP_ENTRY_NS 100000
`define SLEEP_CYCLES_DEF ((`SLEEP_ENTRY_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define CAL_TIME_NS 2000000
`define CAL_CYCLES_DEF ((`CAL_TIME_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

// ----------------------------------------
// Result coding
// ----------------------------------------
`define RES_W 24
`define RAW_W_DEF 26
`define POS_FULL 24'h7fffff
`define NEG_FULL 24'h800000
`define RESULT_RST 24'h000000

// ----------------------------------------
// Shift clock pulse counts
// ----------------------------------------
`define PULSE_W 5
`define DATA_PULSES 5'h18
`define FORCE_HIGH_PULSE 5'h19
`define CAL_PULSE 5'h1a

`endif

// ==== hw/adc_pkg.sv ====
package adc_pkg;

   // Gray path: calibrate -> convert -> ready -> sleep
   typedef enum logic [1:0] {
      ST_CAL = 2'h0,
      ST_CONV = 2'h1,
      ST_READY = 2'h3,
      ST_SLEEP = 2'h2
   } adc_state_type;

endpackage

// ==== hw/adc_serial_ctrl.sv ====
`include "adc_readout_defs.svh"

// What this block does
// - Each result is a 24-bit two's-complement word.
// - Inputs at or above positive full scale give 7fffff, no wrap.
// - Inputs at or below negative full scale give 800000, no wrap.
// - While awake, a fresh result appears every conversion period unasked.
// - Result leaves MSB first, one bit per shift clock pulse.
// - Partial reads allowed; an unread result is overwritten by the next.
// - Line keeps the last bit until forced high for the update.
// - The 25th pulse forces the line high until the next result.
// - Falling edge of the 26th pulse starts self-calibration.
// - Calibration disconnects inputs, then ends with line low and valid data.
// - A self-calibration runs automatically at power-up.
// - Shift clock held high for the entry delay puts the device to sleep.
// - Sleep may be requested at any point of a readback.
// - While asleep the line stays high and circuitry is shut down.
// - Shift clock low during sleep wakes the device; first result is valid.
// - After 25 pulses then sleep, wakeup runs calibration before ready.
// - A common wakeup makes all sleeping devices sample together.
// - Serial output advances on each rising shift clock edge.

module adc_serial_ctrl
   import adc_pkg::*;
#(
   parameter int RAW_W = `RAW_W_DEF,
   parameter int CONV_CYCLES = `CONV_CYCLES_DEF,
   parameter int UPDATE_CYCLES = `UPDATE_CYCLES_DEF,
   parameter int SLEEP_CYCLES = `SLEEP_CYCLES_DEF,
   parameter int CAL_CYCLES = `CAL_CYCLES_DEF
)(
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic SCLK,
   input wire logic signed [RAW_W-1:0] RAW_SAMPLE,
   output logic READY_SERIAL_OUT,
   output logic SLEEP_ACTIVE,
   output logic INPUTS_DISCONNECTED,
   output logic RESULT_STROBE
);

   localparam int CONV_W = $clog2(CONV_CYCLES + 1);
   localparam int CAL_W = $clog2(CAL_CYCLES + 1);
   localparam int SLP_W = $clog2(SLEEP_CYCLES + 1);

   // ----------------------------------------
   // Shift clock domain
   // ----------------------------------------
   // Free-running toggles; two-state so they start defined
   bit rise_tog_q;
   bit fall_tog_q;

   always_ff @(posedge SCLK) begin
      rise_tog_q <= ~rise_tog_q;
   end

   always_ff @(negedge SCLK) begin
      fall_tog_q <= ~fall_tog_q;
   end

   // ----------------------------------------
   // Crossing into the master clock
   // ----------------------------------------
   logic rise_s1_q;
   logic rise_s2_q;
   logic rise_s3_q;
   logic fall_s1_q;
   logic fall_s2_q;
   logic fall_s3_q;

   // Not reset: chain flushes while reset is held
   always_ff @(posedge MCLK) begin
      if (CE) begin
         rise_s1_q <= rise_tog_q;
         rise_s2_q <= rise_s1_q;
         rise_s3_q <= rise_s2_q;
         fall_s1_q <= fall_tog_q;
         fall_s2_q <= fall_s1_q;
         fall_s3_q <= fall_s2_q;
      end
   end

   wire rise_evt = rise_s2_q ^ rise_s3_q;
   wire fall_evt = fall_s2_q ^ fall_s3_q;
   // Level from toggle parity; valid as SCLK starts low at power-up
   wire sclk_high = rise_s2_q ^ fall_s2_q;

   // ----------------------------------------
   // Result coding
   // ----------------------------------------
   function automatic logic [`RES_W-1:0] clip_result(
      input logic signed [RAW_W-1:0] raw
   );
      logic over;
      over = (raw[RAW_W-1:`RES_W-1] != {(RAW_W-`RES_W+1){raw[RAW_W-1]}});
      if (!over) begin
         clip_result = raw[`RES_W-1:0];
      end else if (raw[RAW_W-1]) begin
         clip_result = `NEG_FULL;
      end else begin
         clip_result = `POS_FULL;
      end
   endfunction

   wire [`RES_W-1:0] clipped = clip_result(RAW_SAMPLE);

   // ----------------------------------------
   // State and counters
   // ----------------------------------------
   adc_state_type state_q;
   adc_state_type state_d;
   logic [CONV_W-1:0] conv_cnt_q;
   logic [CONV_W-1:0] conv_cnt_d;
   logic [CAL_W-1:0] cal_cnt_q;
   logic [CAL_W-1:0] cal_cnt_d;
   logic [SLP_W-1:0] sleep_cnt_q;
   logic [SLP_W-1:0] sleep_cnt_d;
   logic [`PULSE_W-1:0] pulse_cnt_q;
   logic [`PULSE_W-1:0] pulse_cnt_d;
   logic [`RES_W-1:0] shift_q;
   logic [`RES_W-1:0] shift_d;
   logic line_d;
   logic cal_wake_q;
   logic cal_wake_d;
   logic load;

   wire conv_done = (conv_cnt_q == CONV_W'(CONV_CYCLES - 1));
   wire in_update = (conv_cnt_q >= CONV_W'(CONV_CYCLES - UPDATE_CYCLES));
   wire cal_done = (cal_cnt_q == CAL_W'(CAL_CYCLES - 1));
   wire sleep_due = sclk_high && (sleep_cnt_q == SLP_W'(SLEEP_CYCLES - 1));
   wire awake_idle = (state_q == ST_CONV) || (state_q == ST_READY);
   wire data_left = (pulse_cnt_q < `DATA_PULSES);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      conv_cnt_d = conv_done ? '0 : conv_cnt_q + CONV_W'(1);
      cal_cnt_d = '0;
      pulse_cnt_d = pulse_cnt_q;
      shift_d = shift_q;
      line_d = READY_SERIAL_OUT;
      cal_wake_d = cal_wake_q;
      load = 1'b0;
      sleep_cnt_d = '0;
      if (awake_idle && sclk_high && !sleep_due) begin
         sleep_cnt_d = sleep_cnt_q + SLP_W'(1);
      end
      unique case (state_q)
         ST_CAL: begin
            // Inputs disconnected; shift clock ignored
            cal_cnt_d = cal_cnt_q + CAL_W'(1);
            conv_cnt_d = '0;
            line_d = 1'b1;
            if (cal_done) begin
               load = 1'b1;
            end
         end
         ST_CONV: begin
            line_d = 1'b1;
            if (conv_done) begin
               load = 1'b1;
            end
         end
         ST_READY: begin
            if (rise_evt) begin
               if (pulse_cnt_q < `CAL_PULSE) begin
                  pulse_cnt_d = pulse_cnt_q + `PULSE_W'(1);
               end
               if (data_left) begin
                  line_d = shift_q[`RES_W-1];
                  shift_d = {shift_q[`RES_W-2:0], 1'b0};
               end else begin
                  line_d = 1'b1;
               end
            end
            if (in_update) begin
               line_d = 1'b1;
            end
            if (conv_done) begin
               load = 1'b1;
            end
            if (fall_evt && pulse_cnt_q == `CAL_PULSE) begin
               state_d = ST_CAL;
               line_d = 1'b1;
               conv_cnt_d = '0;
            end
         end
         ST_SLEEP: begin
            line_d = 1'b1;
            conv_cnt_d = '0;
            if (!sclk_high) begin
               // Wake from a common edge restarts all converters together
               state_d = cal_wake_q ? ST_CAL : ST_CONV;
               cal_wake_d = 1'b0;
            end
         end
      endcase
      if (load) begin
         state_d = ST_READY;
         shift_d = clipped;
         pulse_cnt_d = '0;
         line_d = 1'b0;
      end
      if (sleep_due && awake_idle) begin
         // Accepted mid-readback; 25 pulses arm calibration on wakeup
         state_d = ST_SLEEP;
         // A result landing on sleep entry is held, not announced
         load = 1'b0;
         cal_wake_d = (pulse_cnt_q >= `FORCE_HIGH_PULSE);
         line_d = 1'b1;
         conv_cnt_d = '0;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         state_q <= ST_CAL;
         conv_cnt_q <= '0;
         cal_cnt_q <= '0;
         sleep_cnt_q <= '0;
         pulse_cnt_q <= '0;
         shift_q <= `RESULT_RST;
         cal_wake_q <= 1'b0;
      end else if (CE) begin
         state_q <= state_d;
         conv_cnt_q <= conv_cnt_d;
         cal_cnt_q <= cal_cnt_d;
         sleep_cnt_q <= sleep_cnt_d;
         pulse_cnt_q <= pulse_cnt_d;
         shift_q <= shift_d;
         cal_wake_q <= cal_wake_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         READY_SERIAL_OUT <= 1'b1;
         SLEEP_ACTIVE <= 1'b0;
         INPUTS_DISCONNECTED <= 1'b1;
         RESULT_STROBE <= 1'b0;
      end else if (CE) begin
         READY_SERIAL_OUT <= line_d;
         SLEEP_ACTIVE <= (state_d == ST_SLEEP);
         INPUTS_DISCONNECTED <= (state_d == ST_CAL);
         RESULT_STROBE <= load;
      end
   end

endmodule

// ==== testbench/adc_serial_ctrl_monitor.sv ====
module adc_serial_ctrl_monitor
   import adc_pkg::*;
#(
   parameter int SLEEP_CYCLES = 50
)(
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic SCLK,
   input wire logic READY_SERIAL_OUT,
   input wire logic SLEEP_ACTIVE,
   input wire logic INPUTS_DISCONNECTED,
   input wire logic RESULT_STROBE
);
   int hi_cnt;
   int lo_cnt;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   // ----------------------------------------
   // Cycles with shift clock held high or held low
   // ----------------------------------------
   always_ff @(posedge MCLK) begin
      hi_cnt <= SCLK ? hi_cnt + 1 : 0;
      lo_cnt <= SCLK ? 0 : lo_cnt + 1;
   end
   a_power_up_cal: assert property ($rose(RST_B) |-> INPUTS_DISCONNECTED)
      else $error("no calibration after reset");
   a_strobe_line_low: assert property (RESULT_STROBE |-> !READY_SERIAL_OUT)
      else $error("strobe with line high");
   a_sleep_line_high: assert property (SLEEP_ACTIVE |-> READY_SERIAL_OUT)
      else $error("line low in sleep");
   a_cal_line_high: assert property (INPUTS_DISCONNECTED |-> READY_SERIAL_OUT)
      else $error("line low in calibration");
   a_cal_end_ready: assert property ($fell(INPUTS_DISCONNECTED) |-> ##[0:1] RESULT_STROBE)
      else $error("calibration end without result");
   a_sleep_delay: assert property ($rose(SLEEP_ACTIVE) |-> hi_cnt >= SLEEP_CYCLES)
      else $error("sleep entered too early");
   a_sleep_sclk_high: assert property (SLEEP_ACTIVE |-> lo_cnt <= 5)
      else $error("asleep with shift clock low");
   a_wake_on_low: assert property (SLEEP_ACTIVE && !SCLK |-> ##[1:8] !SLEEP_ACTIVE)
      else $error("no wakeup");
   c_cal_end: cover property ($fell(INPUTS_DISCONNECTED));
   c_sleep: cover property ($rose(SLEEP_ACTIVE));
   c_wake: cover property ($fell(SLEEP_ACTIVE));
endmodule

// ==== testbench/sclk_host.sv ====
module sclk_host;
   timeunit 1ns;
   timeprecision 100ps;
   logic sclk = 1'b0;
   task automatic pulse(input int n);
      repeat (n) begin
         sclk = 1'b1;
         #15 sclk = 1'b0;
         #15;
      end
   endtask
   task automatic level(input logic lvl);
      sclk = lvl;
   endtask
endmodule

// ==== testbench/test_adc_serial_ctrl.sv ====
module test_adc_serial_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic signed [25:0] raw = 26'h0;
   logic ready_out, sleep_on, cal_on, strobe;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [25:0] raws [7] = '{26'h0, 26'h1, 26'h3ffffff, 26'h7fffff, 26'h1000000,
      26'h3800000, 26'h2000000};
   logic [23:0] exps [7] = '{24'h0, 24'h1, 24'hffffff, 24'h7fffff, 24'h7fffff,
      24'h800000, 24'h800000};
   sclk_host host();
   adc_serial_ctrl #(.CONV_CYCLES(400), .UPDATE_CYCLES(20), .SLEEP_CYCLES(50),
      .CAL_CYCLES(100)) dut (.MCLK(mclk), .RST_B(rst_b), .CE(ce), .SCLK(host.sclk),
      .RAW_SAMPLE(raw), .READY_SERIAL_OUT(ready_out), .SLEEP_ACTIVE(sleep_on),
      .INPUTS_DISCONNECTED(cal_on), .RESULT_STROBE(strobe));
   initial forever #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 12000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_strobe();
      int n;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (strobe !== 1'b1 && n < 600);
      check(24'(strobe), 24'h1);
   endtask
   task automatic read(input int n, output logic [23:0] v);
      v = 24'h0;
      repeat (n) begin
         host.pulse(1);
         #30 v = {v[22:0], ready_out};
      end
   endtask
   task automatic t_codes();
      logic [23:0] v;
      for (int i = 0; i < 7; i++) begin
         @(negedge mclk);
         raw = raws[i];
         wait_strobe();
         read(24, v);
         check(v, exps[i]);
         host.pulse(1);
         #30 check(24'({cal_on, ready_out}), 24'h1);
      end
      $display("test codes done");
   endtask
   task automatic t_partial();
      logic [23:0] v;
      wait_strobe();
      read(3, v);
      repeat (40) @(negedge mclk);
      ce = 1'b0;
      repeat (50) @(negedge mclk);
      check(24'({strobe, ready_out}), 24'(v[0]));
      ce = 1'b1;
      repeat (10) @(negedge mclk);
      check(24'(ready_out), 24'(v[0]));
      raw = 26'h5;
      wait_strobe();
      read(24, v);
      check(v, 24'h5);
      $display("test partial done");
   endtask
   task automatic t_cal();
      logic [23:0] v;
      wait_strobe();
      read(24, v);
      host.pulse(2);
      repeat (10) @(negedge mclk);
      check(24'({cal_on, ready_out}), 24'h3);
      wait_strobe();
      check(24'({cal_on, ready_out}), 24'h0);
      $display("test cal done");
   endtask
   task automatic t_sleep(input int n, input logic [23:0] exp_cal);
      logic [23:0] v;
      wait_strobe();
      read(n, v);
      host.level(1'b1);
      repeat (70) @(negedge mclk);
      check(24'({sleep_on, ready_out}), 24'h3);
      raw = 26'h3fffffe;
      host.level(1'b0);
      repeat (8) @(negedge mclk);
      check(24'({sleep_on, cal_on}), exp_cal);
      wait_strobe();
      read(24, v);
      check(v, 24'hfffffe);
      $display("test sleep %0d done", n);
   endtask
   initial begin
      repeat (12) @(negedge mclk);
      rst_b = 1'b1;
      @(negedge mclk);
      check(24'({cal_on, ready_out}), 24'h3);
      wait_strobe();
      t_codes();
      t_partial();
      t_cal();
      t_sleep(3, 24'h0);
      t_sleep(25, 24'h1);
      finish_test();
   end
endmodule
bind adc_serial_ctrl adc_serial_ctrl_monitor #(.SLEEP_CYCLES(SLEEP_CYCLES)) mon (.MCLK(MCLK),
   .RST_B(RST_B), .SCLK(SCLK), .READY_SERIAL_OUT(READY_SERIAL_OUT),
   .SLEEP_ACTIVE(SLEEP_ACTIVE), .INPUTS_DISCONNECTED(INPUTS_DISCONNECTED),
   .RESULT_STROBE(RESULT_STROBE));
